// *** dv/psh_master_model.sv ***
// Serial master model: frames chip select and sclk, shifts command and data bytes.
// Assumes the shared pin has a pull-up; the bench resolves its level.
`timescale 1ns/1ps
`default_nettype none
module psh_master_model (
  // Link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  output logic sdi_oe_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  input wire logic line_i
);
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    sdi_o = 1'b1;
    sdi_oe_o = 1'b0;
  end
  // Byte k of a transfer sits in bits 8k+7:8k
  task automatic xfer(input logic rd, input logic inc, input logic [5:0] idx, input int n,
                      input logic tw, input logic [63:0] wd, output logic [63:0] rdat);
    logic [7:0] cmd;
    logic b;
    cmd = {rd, inc, idx};
    rdat = '0;
    #7 cs_n_o = 1'b0;
    #40;
    for (int i = 0; i < 8 + 8 * n; i++) begin
      sclk_o = 1'b0;
      if (i < 8) begin
        sdi_oe_o = 1'b1;
        sdi_o = cmd[7 - i];
      end else if (!rd) begin
        sdi_o = wd[8 * ((i - 8) / 8) + 7 - (i % 8)];
      end else begin
        // Never leave a stale bit on a line the master does not own
        sdi_oe_o = !tw;
        sdi_o = !sdi_o;
      end
      #40 sclk_o = 1'b1;
      b = tw ? line_i : (sdo_oe_i ? sdo_i : 1'bx);
      if (i >= 8) begin
        rdat[8 * ((i - 8) / 8) + 7 - (i % 8)] = b;
      end
      #40;
    end
    sdi_oe_o = 1'b0;
    cs_n_o = 1'b1;
    #1000;
  endtask
endmodule
`default_nettype wire

// *** dv/psh_port_checker.sv ***
// Checker for the pressure sensor serial port, bound to the top module.
// Assumes sclk idles high outside frames and chip select high resets the link.
`timescale 1ns/1ps
`default_nettype none
module psh_port_checker
  import psh_pkg::*;
#(
  parameter logic [7:0] PART_ID = psh_pkg::PSH_PART_ID_DEFAULT,
  parameter int unsigned DEPTH = psh_pkg::PSH_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic serial_in_pin_i,
  input wire logic serial_in_pin_o,
  input wire logic serial_in_pin_oe_o,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe_o,
  // Converter side and outputs
  input wire logic press_valid_i,
  input wire logic [psh_pkg::PSH_PRESS_W-1:0] press_data_i,
  input wire logic [15:0] temp_data_i,
  input wire logic int_o,
  input wire logic [7:0] power_ctrl_o,
  input wire logic [7:0] avg_cfg_o
);
  // Rising edges so far in the frame
  logic [6:0] edges_r;
  logic dir_r;
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      edges_r <= 7'h00;
      dir_r <= 1'b0;
    end else begin
      edges_r <= edges_r + 7'h01;
      if (edges_r == 7'h00) begin
        dir_r <= serial_in_pin_i;
      end
    end
  end
  sequence s_cmd_phase;
    edges_r < 7'h08;
  endsequence
  sequence s_data_phase;
    edges_r >= 7'h08;
  endsequence
  sequence s_frame_end;
    $rose(cs_n_i);
  endsequence
  property p_quiet_cmd;
    @(posedge sclk_i) disable iff (cs_n_i) s_cmd_phase |-> !serial_out_pin_oe_o && !serial_in_pin_oe_o;
  endproperty
  a_quiet_cmd: assert property (p_quiet_cmd) else $error("pin driven in command bits");
  property p_read_drive;
    @(posedge sclk_i) disable iff (cs_n_i) s_data_phase ##0 dir_r |-> serial_out_pin_oe_o ^ serial_in_pin_oe_o;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data not driven");
  property p_write_quiet;
    @(posedge sclk_i) disable iff (cs_n_i) s_data_phase ##0 !dir_r |-> !serial_out_pin_oe_o && !serial_in_pin_oe_o;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("pin driven in write");
  property p_release;
    @(posedge clk_i) disable iff (reset_i) s_frame_end |-> ##[0:2] !serial_out_pin_oe_o && !serial_in_pin_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("pin held after frame");
  property p_one_driver;
    @(posedge clk_i) disable iff (reset_i) !(serial_out_pin_oe_o && serial_in_pin_oe_o);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both pins driven");
  property p_idle_off;
    @(posedge clk_i) disable iff (reset_i) cs_n_i [*3] |-> !serial_out_pin_oe_o && !serial_in_pin_oe_o;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("pin driven while idle");
  property p_edge_only;
    @(posedge clk_i) disable iff (reset_i) sclk_i && $past(sclk_i) && !cs_n_i && !$past(cs_n_i)
      |-> $stable(serial_out_pin_o) && $stable(serial_in_pin_o);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("data moved while sclk high");
  property p_cfg_in_frame;
    @(posedge clk_i) disable iff (reset_i) $changed(power_ctrl_o) || $changed(avg_cfg_o) |-> !$past(cs_n_i, 6);
  endproperty
  a_cfg_in_frame: assert property (p_cfg_in_frame) else $error("config changed with no write");
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the pressure sensor serial port.
// Assumes the master model owns the link; converter inputs move on clk_i.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import psh_pkg::*;
  // Arbitrary identifier value
  localparam logic [7:0] PID = 8'h3c;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic press_valid_i = 1'b0;
  logic [23:0] press_data_i = 24'h00_0000;
  logic [15:0] temp_data_i = 16'h0000;
  logic sclk, cs_n, m_d, m_oe, line, si_o, si_oe, so_o, so_oe, int_o, tw;
  logic [7:0] pwr, avg;
  logic [63:0] rd;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  psh_master_model m (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(m_d), .sdi_oe_o(m_oe), .sdo_i(so_o),
    .sdo_oe_i(so_oe), .line_i(line));
  // Shared pin with pull-up
  assign line = si_oe ? si_o : (m_oe ? m_d : 1'b1);
  psh_port #(.PART_ID(PID)) uut (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .serial_in_pin_i(line), .serial_in_pin_o(si_o), .serial_in_pin_oe_o(si_oe),
    .serial_out_pin_o(so_o), .serial_out_pin_oe_o(so_oe), .press_valid_i(press_valid_i),
    .press_data_i(press_data_i), .temp_data_i(temp_data_i), .int_o(int_o),
    .power_ctrl_o(pwr), .avg_cfg_o(avg));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_reg(input logic [6:0] idx, input int n, input logic inc, input logic [63:0] exp);
    m.xfer(1'b1, inc, idx[5:0], n, tw, 64'h0, rd);
    chk(rd, exp);
  endtask
  task automatic wr_reg(input logic [6:0] idx, input int n, input logic inc, input logic [63:0] wd);
    m.xfer(1'b0, inc, idx[5:0], n, tw, wd, rd);
  endtask
  task automatic push(input logic [23:0] p);
    @(posedge clk_i);
    press_data_i <= p;
    temp_data_i <= p[15:0];
    press_valid_i <= 1'b1;
    @(posedge clk_i);
    press_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    tw = 1'b0;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_reg(PSH_IDX_PWR_CTRL, 8, 1'b1, 64'h01ff_0000_3000_3f00);
    rd_reg(PSH_IDX_REF_LOW, 3, 1'b1, 64'h0);
    rd_reg(PSH_IDX_PART_ID, 2, 1'b0, {48'h0, PID, PID});
    rd_reg(PSH_IDX_AVG_CFG, 1, 1'b0, 64'h0);
    rd_reg(7'h30, 1, 1'b0, 64'h0);
    wr_reg(PSH_IDX_REF_LOW, 3, 1'b1, 64'h3c_5aa5);
    rd_reg(PSH_IDX_REF_LOW, 3, 1'b1, 64'h3c_5aa5);
    wr_reg(PSH_IDX_THS_LOW, 2, 1'b0, 64'h2211);
    rd_reg(PSH_IDX_THS_LOW, 2, 1'b1, 64'hff22);
    wr_reg(PSH_IDX_PART_ID, 1, 1'b0, 64'h0);
    rd_reg(PSH_IDX_PART_ID, 1, 1'b0, {56'h0, PID});
    wr_reg(PSH_IDX_AVG_CFG, 2, 1'b0, 64'h35aa);
    chk({56'h0, avg}, 64'h35);
    wr_reg(PSH_IDX_PWR_CTRL, 1, 1'b0, 64'h02);
    chk({56'h0, pwr}, 64'h02);
    push(24'h12_3456);
    rd_reg(PSH_IDX_EVENTS, 1, 1'b0, 64'h0);
    rd_reg(PSH_IDX_POUT_LOW, 3, 1'b1, 64'h12_3456);
    rd_reg(PSH_IDX_EVENTS, 1, 1'b0, 64'h01);
    wr_reg(PSH_IDX_INT_MASK, 1, 1'b0, 64'h37);
    rd_reg(PSH_IDX_INT_CAUSE, 1, 1'b0, 64'h0);
    chk({63'h0, int_o}, 64'h0);
    for (int k = 1; k <= 17; k++) begin
      push(24'h0a_0000 + 24'(k));
    end
    rd_reg(PSH_IDX_EVENTS, 1, 1'b0, 64'h06);
    chk({63'h0, int_o}, 64'h1);
    rd_reg(PSH_IDX_INT_CAUSE, 1, 1'b0, 64'h08);
    chk({63'h0, int_o}, 64'h0);
    // Active-low pin polarity: no cause pending, so the pin must sit high
    wr_reg(PSH_IDX_INT_PIN, 1, 1'b0, 64'h40);
    chk({63'h0, int_o}, 64'h1);
    wr_reg(PSH_IDX_INT_PIN, 1, 1'b0, 64'h00);
    chk({63'h0, int_o}, 64'h0);
    rd_reg(PSH_IDX_POUT_LOW, 3, 1'b1, 64'h0a_0002);
    rd_reg(PSH_IDX_EVENTS, 1, 1'b0, 64'h04);
    wr_reg(PSH_IDX_RATE_CTRL, 1, 1'b0, 64'hb0);
    tw = 1'b1;
    rd_reg(PSH_IDX_PART_ID, 2, 1'b0, {48'h0, PID, PID});
    rd_reg(PSH_IDX_REF_LOW, 3, 1'b1, 64'h3c_5aa5);
    rd_reg(PSH_IDX_RATE_CTRL, 1, 1'b0, 64'hb0);
    report_and_stop();
  end
endmodule
bind psh_port psh_port_checker #(.PART_ID(PART_ID), .DEPTH(DEPTH)) chk_i (.clk_i(clk_i), .reset_i(reset_i),
  .sclk_i(sclk_i), .cs_n_i(cs_n_i), .serial_in_pin_i(serial_in_pin_i), .serial_in_pin_o(serial_in_pin_o),
  .serial_in_pin_oe_o(serial_in_pin_oe_o), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_pin_oe_o(serial_out_pin_oe_o), .press_valid_i(press_valid_i), .press_data_i(press_data_i),
  .temp_data_i(temp_data_i), .int_o(int_o), .power_ctrl_o(power_ctrl_o), .avg_cfg_o(avg_cfg_o));
`default_nettype wire

// *** logic/psh_pkg.sv ***
// Package for the pressure sensor serial port: register indices, reset values, field positions.
// Assumes a 6-bit index on the wire, widened to a 7-bit register index inside.
package psh_pkg;
  localparam int unsigned PSH_IDX_W = 7;
  localparam int unsigned PSH_DATA_W = 8;
  localparam int unsigned PSH_PRESS_W = 24;
  localparam int unsigned PSH_FIFO_DEPTH = 16;
  localparam logic [6:0] PSH_IDX_REF_LOW = 7'h08;
  localparam logic [6:0] PSH_IDX_REF_MID = 7'h09;
  localparam logic [6:0] PSH_IDX_REF_HIGH = 7'h0a;
  localparam logic [6:0] PSH_IDX_PART_ID = 7'h0f;
  localparam logic [6:0] PSH_IDX_AVG_CFG = 7'h10;
  localparam logic [6:0] PSH_IDX_PWR_CTRL = 7'h20;
  localparam logic [6:0] PSH_IDX_INT_MASK = 7'h21;
  localparam logic [6:0] PSH_IDX_INT_PIN = 7'h22;
  localparam logic [6:0] PSH_IDX_RATE_CTRL = 7'h23;
  localparam logic [6:0] PSH_IDX_INT_CAUSE = 7'h24;
  localparam logic [6:0] PSH_IDX_THS_LOW = 7'h25;
  localparam logic [6:0] PSH_IDX_THS_HIGH = 7'h26;
  localparam logic [6:0] PSH_IDX_EVENTS = 7'h27;
  localparam logic [6:0] PSH_IDX_POUT_LOW = 7'h28;
  localparam logic [6:0] PSH_IDX_POUT_MID = 7'h29;
  localparam logic [6:0] PSH_IDX_POUT_HIGH = 7'h2a;
  localparam logic [6:0] PSH_IDX_TOUT_LOW = 7'h2b;
  localparam logic [6:0] PSH_IDX_TOUT_HIGH = 7'h2c;
  localparam logic [7:0] PSH_RST_ZERO = 8'h00;
  localparam logic [7:0] PSH_RST_INT_MASK = 8'h3f;
  localparam logic [7:0] PSH_RST_RATE_CTRL = 8'h30;
  localparam logic [7:0] PSH_RST_THS_HIGH = 8'hff;
  // Arbitrary neutral identifier value
  localparam logic [7:0] PSH_PART_ID_DEFAULT = 8'h5a;
  // Field positions
  localparam int unsigned PSH_RATE_3WIRE_BIT = 7;
  localparam int unsigned PSH_MASK_FULL_BIT = 3;
  localparam int unsigned PSH_MASK_EMPTY_BIT = 4;
  localparam int unsigned PSH_CAUSE_FULL_BIT = 3;
  localparam int unsigned PSH_CAUSE_EMPTY_BIT = 4;
  localparam int unsigned PSH_EV_EMPTY_BIT = 0;
  localparam int unsigned PSH_EV_FULL_BIT = 1;
  localparam int unsigned PSH_EV_OVERRUN_BIT = 2;
  localparam int unsigned PSH_PIN_ACT_LOW_BIT = 6;
  // Frame layout
  localparam logic [4:0] PSH_CMD_BITS = 5'h08;
  localparam logic [2:0] PSH_BIT_LAST = 3'h7;
  typedef enum logic [2:0] {
    PSH_ST_CMD = 3'b001,
    PSH_ST_WDATA = 3'b010,
    PSH_ST_RDATA = 3'b100
  } psh_spi_state_t;
endpackage

// *** logic/psh_port.sv ***
// Serial register port of the pressure sensor with register file and pressure queue.
// Assumes an external master on cs/sclk; sclk idles high; results arrive on clk_i.
// Function
// - Read is 16 clocks, plus 8 per byte.
// - Second bit chooses fixed or incrementing index.
// - Bits 2 to 7 carry index, MSB first.
// - Read data on bits 8-15, MSB first.
// - Further read bytes while chip select low.
// - Write starts with 0, 16 clocks plus 8.
// - Write bytes captured MSB first, stored per index.
// - Three-wire select routes read data onto input pin.
// - Three-wire mode keeps read and multibyte framing.
// - Queue holds sixteen pressure results.
// - Empty flag high when queue empty.
// - Full flag high when queue full.
// - Arrival while full sets overrun flag.
// - Full queue drops oldest, keeps newest.
// - Reading all three output bytes pops entry.
// - Full or empty raise interrupt through mask.
// - Reading cause register clears it, pin inactive.
// - Registers addressed by seven-bit index; the wire carries six index bits, with the seventh fixed at 0.
// - Calibration contents reloaded at every power-up; none held here, registers take fixed reset values.
// - Data changes on falling, sampled rising edge.
// - Output driven from start of bit 8.
`timescale 1ns/1ps
`default_nettype none
module psh_port
  import psh_pkg::*;
#(
  parameter logic [7:0] PART_ID = psh_pkg::PSH_PART_ID_DEFAULT,
  parameter int unsigned DEPTH = psh_pkg::PSH_FIFO_DEPTH
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic serial_in_pin_i,
  output logic serial_in_pin_o,
  output logic serial_in_pin_oe_o,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  // Pressure results from the converter
  input wire logic press_valid_i,
  input wire logic [psh_pkg::PSH_PRESS_W-1:0] press_data_i,
  input wire logic [15:0] temp_data_i,
  // Interrupt and control outputs
  output logic int_o,
  output logic [7:0] power_ctrl_o,
  output logic [7:0] avg_cfg_o
);
  import psh_pkg::*;
  localparam int unsigned PW = $clog2(DEPTH);

  // Link domain state, clocked by sclk, reset while chip select is high
  typedef struct packed {
    psh_spi_state_t st_r;
    logic [2:0] bit_r;
    logic read_r;
    logic incr_r;
    logic [7:0] sh_r;
    logic [5:0] idx_r;
    logic wr_tog_r;
    logic rd_tog_r;
    logic [5:0] wr_idx_r;
    logic [7:0] wr_data_r;
    logic [5:0] rd_idx_r;
  } psh_link_t;
  psh_link_t l_r;
  psh_link_t l_nxt;
  logic link_rst;
  logic [7:0] rd_byte;
  logic [6:0] rd_sel;
  logic three_wire;

  // Out-of-frame resets the link logic; sclk may stand still between frames
  assign link_rst = reset_i | cs_n_i;

  always_comb begin
    l_nxt = l_r;
    l_nxt.sh_r = {l_r.sh_r[6:0], serial_in_pin_i};
    l_nxt.bit_r = l_r.bit_r + 3'h1;
    case (l_r.st_r)
      PSH_ST_CMD: begin
        if (l_r.bit_r == PSH_BIT_LAST) begin
          l_nxt.read_r = l_r.sh_r[6];
          l_nxt.incr_r = l_r.sh_r[5];
          l_nxt.idx_r = {l_r.sh_r[4:0], serial_in_pin_i};
          l_nxt.st_r = l_r.sh_r[6] ? PSH_ST_RDATA : PSH_ST_WDATA;
          if (l_r.sh_r[6]) begin
            l_nxt.rd_idx_r = {l_r.sh_r[4:0], serial_in_pin_i};
          end
        end
      end
      PSH_ST_WDATA: begin
        if (l_r.bit_r == PSH_BIT_LAST) begin
          l_nxt.wr_idx_r = l_r.idx_r;
          l_nxt.wr_data_r = {l_r.sh_r[6:0], serial_in_pin_i};
          l_nxt.wr_tog_r = ~l_r.wr_tog_r;
          if (l_r.incr_r) begin
            l_nxt.idx_r = l_r.idx_r + 6'h01;
          end
        end
      end
      PSH_ST_RDATA: begin
        if (l_r.bit_r == PSH_BIT_LAST) begin
          l_nxt.rd_idx_r = l_r.incr_r ? l_r.idx_r + 6'h01 : l_r.idx_r;
          l_nxt.idx_r = l_nxt.rd_idx_r;
          l_nxt.rd_tog_r = ~l_r.rd_tog_r;
        end
      end
      default: begin
        l_nxt.st_r = PSH_ST_CMD;
      end
    endcase
  end

  // Toggles survive the frame reset, so they live outside the reset-on-cs struct
  typedef struct packed {
    logic wr_tog_r;
    logic rd_tog_r;
    logic [5:0] wr_idx_r;
    logic [7:0] wr_data_r;
    logic [5:0] rd_idx_r;
  } psh_hold_t;
  psh_hold_t h_r;
  psh_hold_t h_nxt;
  always_comb begin
    h_nxt = h_r;
    if (l_r.st_r == PSH_ST_WDATA && l_r.bit_r == PSH_BIT_LAST) begin
      h_nxt.wr_idx_r = l_nxt.wr_idx_r;
      h_nxt.wr_data_r = l_nxt.wr_data_r;
      h_nxt.wr_tog_r = ~h_r.wr_tog_r;
    end
    // Side effects follow the byte just shifted out, so a clear or pop never races its load
    if (l_r.st_r == PSH_ST_RDATA && l_r.bit_r == PSH_BIT_LAST) begin
      h_nxt.rd_idx_r = l_r.rd_idx_r;
      h_nxt.rd_tog_r = ~h_r.rd_tog_r;
    end
  end

  always_ff @(posedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      l_r <= '{st_r: PSH_ST_CMD, default: '0};
    end else begin
      l_r <= l_nxt;
    end
  end
  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  // Read byte is looked up live from the system registers; they change only on
  // host writes, read clears and pops, or results, and the byte is loaded at the falling edge before bit 8.
  typedef struct packed {
    logic [7:0] out_r;
    logic drive_r;
  } psh_tx_t;
  psh_tx_t t_r;
  psh_tx_t t_nxt;
  always_comb begin
    t_nxt = t_r;
    if (l_r.read_r && l_r.bit_r == 3'h0) begin
      t_nxt.out_r = rd_byte;
      t_nxt.drive_r = 1'b1;
    end else begin
      t_nxt.out_r = {t_r.out_r[6:0], 1'b0};
    end
  end
  always_ff @(negedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end
  assign serial_out_pin_o = t_r.out_r[7];
  assign serial_out_pin_oe_o = t_r.drive_r & ~three_wire;
  assign serial_in_pin_o = t_r.out_r[7];
  assign serial_in_pin_oe_o = t_r.drive_r & three_wire;

  // System domain: register file and queue
  typedef struct packed {
    logic [7:0] ref_low_r;
    logic [7:0] ref_mid_r;
    logic [7:0] ref_high_r;
    logic [7:0] avg_cfg_r;
    logic [7:0] pwr_ctrl_r;
    logic [7:0] int_mask_r;
    logic [7:0] int_pin_r;
    logic [7:0] rate_ctrl_r;
    logic [7:0] int_cause_r;
    logic [7:0] ths_low_r;
    logic [7:0] ths_high_r;
    logic overrun_r;
    logic [2:0] read_seen_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW-1:0] wr_ptr_r;
    logic [PW:0] count_r;
    logic [15:0] temp_r;
    logic int_r;
  } psh_sys_t;
  psh_sys_t s_r;
  psh_sys_t s_nxt;
  logic [PSH_PRESS_W-1:0] queue_r [DEPTH];
  logic wr_pulse;
  logic rd_pulse;
  logic [21:0] held;
  logic [5:0] held_wr_idx;
  logic [7:0] held_wr_data;
  logic [5:0] held_rd_idx;
  logic q_empty;
  logic q_full;
  logic [PSH_PRESS_W-1:0] head;

  psh_toggle_sync u_wr_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .toggle_i(h_r.wr_tog_r),
    .pulse_o(wr_pulse)
  );
  psh_toggle_sync u_rd_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .toggle_i(h_r.rd_tog_r),
    .pulse_o(rd_pulse)
  );
  // Words change on the same sclk edge as each toggle and hold for several cycles after it, so a plain capture is used
  psh_sync #(.WIDTH(20)) u_word_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({h_r.wr_idx_r, h_r.wr_data_r, h_r.rd_idx_r}),
    .q_o(held[19:0])
  );
  assign held[21:20] = 2'b00;
  assign held_wr_idx = held[19:14];
  assign held_wr_data = held[13:6];
  assign held_rd_idx = held[5:0];

  assign three_wire = s_r.rate_ctrl_r[PSH_RATE_3WIRE_BIT];
  assign q_empty = (s_r.count_r == '0);
  assign q_full = (s_r.count_r == DEPTH[PW:0]);
  assign head = queue_r[s_r.rd_ptr_r];
  assign rd_sel = {1'b0, l_r.rd_idx_r};

  always_comb begin
    case (rd_sel)
      PSH_IDX_REF_LOW: rd_byte = s_r.ref_low_r;
      PSH_IDX_REF_MID: rd_byte = s_r.ref_mid_r;
      PSH_IDX_REF_HIGH: rd_byte = s_r.ref_high_r;
      PSH_IDX_PART_ID: rd_byte = PART_ID;
      PSH_IDX_AVG_CFG: rd_byte = s_r.avg_cfg_r;
      PSH_IDX_PWR_CTRL: rd_byte = s_r.pwr_ctrl_r;
      PSH_IDX_INT_MASK: rd_byte = s_r.int_mask_r;
      PSH_IDX_INT_PIN: rd_byte = s_r.int_pin_r;
      PSH_IDX_RATE_CTRL: rd_byte = s_r.rate_ctrl_r;
      PSH_IDX_INT_CAUSE: rd_byte = s_r.int_cause_r;
      PSH_IDX_THS_LOW: rd_byte = s_r.ths_low_r;
      PSH_IDX_THS_HIGH: rd_byte = s_r.ths_high_r;
      PSH_IDX_EVENTS: rd_byte = {5'h00, s_r.overrun_r, q_full, q_empty};
      PSH_IDX_POUT_LOW: rd_byte = head[7:0];
      PSH_IDX_POUT_MID: rd_byte = head[15:8];
      PSH_IDX_POUT_HIGH: rd_byte = head[23:16];
      PSH_IDX_TOUT_LOW: rd_byte = s_r.temp_r[7:0];
      PSH_IDX_TOUT_HIGH: rd_byte = s_r.temp_r[15:8];
      default: rd_byte = PSH_RST_ZERO;
    endcase
  end

  always_comb begin
    logic push;
    logic pop;
    logic [6:0] widx;
    logic [6:0] ridx;
    push = press_valid_i;
    pop = 1'b0;
    widx = {1'b0, held_wr_idx};
    ridx = {1'b0, held_rd_idx};
    s_nxt = s_r;
    if (wr_pulse) begin
      case (widx)
        PSH_IDX_REF_LOW: s_nxt.ref_low_r = held_wr_data;
        PSH_IDX_REF_MID: s_nxt.ref_mid_r = held_wr_data;
        PSH_IDX_REF_HIGH: s_nxt.ref_high_r = held_wr_data;
        PSH_IDX_AVG_CFG: s_nxt.avg_cfg_r = held_wr_data;
        PSH_IDX_PWR_CTRL: s_nxt.pwr_ctrl_r = held_wr_data;
        PSH_IDX_INT_MASK: s_nxt.int_mask_r = held_wr_data;
        PSH_IDX_INT_PIN: s_nxt.int_pin_r = held_wr_data;
        PSH_IDX_RATE_CTRL: s_nxt.rate_ctrl_r = held_wr_data;
        PSH_IDX_THS_LOW: s_nxt.ths_low_r = held_wr_data;
        PSH_IDX_THS_HIGH: s_nxt.ths_high_r = held_wr_data;
        default: s_nxt.int_pin_r = s_r.int_pin_r;
      endcase
    end
    if (rd_pulse) begin
      if (ridx == PSH_IDX_INT_CAUSE) begin
        s_nxt.int_cause_r = PSH_RST_ZERO;
      end
      if (!q_empty) begin
        case (ridx)
          PSH_IDX_POUT_LOW: s_nxt.read_seen_r[0] = 1'b1;
          PSH_IDX_POUT_MID: s_nxt.read_seen_r[1] = 1'b1;
          PSH_IDX_POUT_HIGH: s_nxt.read_seen_r[2] = 1'b1;
          default: s_nxt.read_seen_r = s_r.read_seen_r;
        endcase
      end
    end
    if (&s_nxt.read_seen_r && !q_empty) begin
      pop = 1'b1;
      s_nxt.read_seen_r = 3'b000;
    end
    if (push) begin
      s_nxt.temp_r = temp_data_i;
      s_nxt.wr_ptr_r = s_r.wr_ptr_r + 1'b1;
      if (q_full) begin
        s_nxt.overrun_r = 1'b1;
        pop = 1'b1;
      end
    end
    if (pop) begin
      s_nxt.rd_ptr_r = s_r.rd_ptr_r + 1'b1;
      s_nxt.read_seen_r = 3'b000;
    end
    s_nxt.count_r = s_r.count_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    // Latched on the transition only, so a read clear holds while full; set wins
    if (s_nxt.count_r == DEPTH[PW:0] && !q_full && !s_r.int_mask_r[PSH_MASK_FULL_BIT]) begin
      s_nxt.int_cause_r[PSH_CAUSE_FULL_BIT] = 1'b1;
    end
    if (s_nxt.count_r == '0 && !q_empty && !s_r.int_mask_r[PSH_MASK_EMPTY_BIT]) begin
      s_nxt.int_cause_r[PSH_CAUSE_EMPTY_BIT] = 1'b1;
    end
    s_nxt.int_r = (|s_nxt.int_cause_r) ^ s_r.int_pin_r[PSH_PIN_ACT_LOW_BIT];
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= '0;
      s_r.int_mask_r <= PSH_RST_INT_MASK;
      s_r.rate_ctrl_r <= PSH_RST_RATE_CTRL;
      s_r.ths_high_r <= PSH_RST_THS_HIGH;
    end else begin
      s_r <= s_nxt;
    end
  end
  // Queue storage has no reset; the output registers show head even when the count is zero
  always_ff @(posedge clk_i) begin
    if (press_valid_i) begin
      queue_r[s_r.wr_ptr_r] <= press_data_i;
    end
  end

  assign int_o = s_r.int_r;
  assign power_ctrl_o = s_r.pwr_ctrl_r;
  assign avg_cfg_o = s_r.avg_cfg_r;
endmodule
`default_nettype wire

// *** logic/psh_sync.sv ***
// Two-flop level synchroniser, one per bit.
// Assumes the input is a level that may change at any time.
`timescale 1ns/1ps
`default_nettype none
module psh_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
  } psh_sync_state_t;
  psh_sync_state_t s_r;
  psh_sync_state_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.stage1_r = d_i;
    s_nxt.stage2_r = s_r.stage1_r;
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign q_o = s_r.stage2_r;
endmodule
`default_nettype wire

// *** logic/psh_toggle_sync.sv ***
// Event crossing: a toggle in the source domain becomes a one-cycle pulse in the destination.
// Assumes events in the source are spaced wider than three destination cycles.
`timescale 1ns/1ps
`default_nettype none
module psh_toggle_sync (
  // Destination clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Toggle from the source domain
  input wire logic toggle_i,
  output logic pulse_o
);
  typedef struct packed {
    logic s1_r;
    logic s2_r;
    logic s3_r;
  } psh_tsync_state_t;
  psh_tsync_state_t s_r;
  psh_tsync_state_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1_r = toggle_i;
    s_nxt.s2_r = s_r.s1_r;
    s_nxt.s3_r = s_r.s2_r;
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign pulse_o = s_r.s2_r ^ s_r.s3_r;
endmodule
`default_nettype wire
